/* inc/rrf_regs.svh */
/*
  Register offsets, field positions, codes and lengths of the
  reservation report formatter. Assumes a byte-addressed AXI4-Lite
  slave with 32-bit words.
*/
`ifndef RRF_REGS_SVH
`define RRF_REGS_SVH
// Register byte offsets
`define RRF_A_GEN       8'h00
`define RRF_A_OUT_EVT   8'h04
`define RRF_A_ALLOC     8'h08
`define RRF_A_START     8'h0c
`define RRF_A_STATUS    8'h10
`define RRF_A_TBL_IDX   8'h14
`define RRF_A_KEY_HI    8'h18
`define RRF_A_KEY_LO    8'h1c
`define RRF_A_ELEM      8'h20
`define RRF_A_ENT_CTRL  8'h24
`define RRF_A_VALID     8'h28
// Reserve-in service actions
`define RRF_SA_READ_KEYS  5'h00
`define RRF_SA_READ_RES   5'h01
`define RRF_SA_REPORT_CAP 5'h02
// Reserve-out service actions that move the generation count
`define RRF_PO_REGISTER   5'h00
`define RRF_PO_CLEAR      5'h03
`define RRF_PO_PREEMPT    5'h04
`define RRF_PO_PREEMPT_AB 5'h05
// Scope codes
`define RRF_SCOPE_UNIT    4'h0
`define RRF_SCOPE_ELEM    4'h2
// Field positions
`define RRF_EVT_REJ_BIT   8
`define RRF_ENT_REG_BIT   8
`define RRF_ENT_RES_BIT   9
// Lengths and last-byte offsets in bytes, shift counts, no-entry marker, bus responses
`define RRF_HDR_LEN       16'd8
`define RRF_KEY_LEN       4'd8
`define RRF_DESC_LEN      4'd15
`define RRF_KEY_SHIFT     3
`define RRF_DESC_SHIFT    4
`define RRF_NO_ENTRY      4'd8
`define RRF_BRESP_OK      2'b00
`define RRF_BRESP_ERR     2'b10
`endif

/* inc/rrf_pkg.sv */
/*
  Types of the reservation report formatter: table entry, output
  byte, controller states and the whole controller state.
  Assumes rrf_regs.svh for constants.
*/
package rrf_pkg;
  typedef struct packed {
    logic [63:0] key;
    logic [15:0] elem_addr;
    logic [3:0]  scope;
    logic [3:0]  rtype;
  } rrf_entry_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } rrf_byte_t;

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_HDR   = 5'b00010,
    S_FETCH = 5'b00100,
    S_WAIT  = 5'b01000,
    S_BODY  = 5'b10000
  } rrf_fsm_t;

  typedef struct packed {
    logic        aw_pend;
    logic [7:0]  aw_addr;
    logic        w_pend;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] gen;
    logic [15:0] alloc;
    logic [4:0]  sa;
    logic        err;
    logic [2:0]  tbl_idx;
    logic [31:0] key_hi;
    logic [31:0] key_lo;
    logic [15:0] elem;
    logic [9:0]  ent_ctrl;
    logic [7:0]  reg_vld;
    logic [7:0]  res_vld;
    logic        mem_we;
    rrf_fsm_t    fsm;
    logic        keys;
    logic [15:0] pos;
    logic [15:0] limit;
    logic [15:0] addlen;
    logic [31:0] snap_gen;
    logic [3:0]  rd_idx;
    logic [3:0]  rec_off;
    logic        out_vld;
    rrf_byte_t   out;
  } rrf_state_t;
endpackage : rrf_pkg

/* hdl/rrf_table_mem.sv */
/*
  Eight-entry table of registered keys and reservations.
  One write port, one read port with registered read data.
  Assumes a single clock; contents are not reset.
*/
`timescale 1ns/1ps
module rrf_table_mem
  import rrf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [2:0] waddr,
  input  rrf_entry_t      wdata,
  input  wire logic [2:0] raddr,
  output rrf_entry_t      rdata
);
  rrf_entry_t mem [0:7];

  // Write and registered read
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : rrf_table_mem

/* hdl/rrf_formatter.sv */
/*
  Reservation report formatter: generation counter, key and
  reservation table, and the byte stream of the reserve-in reply.
  Assumes an AXI4-Lite master that keeps one write and one read in
  flight, and a byte sink with valid/ready on the DATA port.
  Register map, byte offsets:
    00 generation count, read only
    04 reserve-out outcome, write only: [4:0] action, bit 8 rejected
    08 allocation length [15:0]
    0c start: [4:0] reserve-in action; reads back the last code
    10 status: bit 0 busy, bit 1 bad action, [31:16] bytes generated
    14 table index [2:0]
    18 staged key, upper word; 1c staged key, lower word
    20 staged element address [15:0]
    24 entry control: [3:0] type, [7:4] scope, bit 8 key, bit 9 reservation
    28 valid masks: [7:0] keys, [15:8] reservations
  Limits: eight table entries; entry and start writes are ignored while
  busy; the capability report is not built and flags a bad action;
  software keeps at most one whole-unit reservation in the table.
  Reply bytes leave through a one-deep output register; the sink may stall.
*/
// Chosen here: the register addresses and the AXI4-Lite slave port.
// How it works
// - Count register, clear, preempt and preempt-abort outcomes in a 32-bit counter.
// - Reserve-in, reserve, release and rejected commands leave the counter alone.
// - Reset clears the counter whatever persist-through-power-loss says.
// - Key list: count, length, then eight-byte keys from byte eight.
// - Key-list length holds the full key byte count despite truncation.
// - Send only bytes below the allocation length; no error for truncation.
// - Reservation list: count, length (total minus eight), descriptors from byte eight.
// - Reservation length counts all descriptor bytes, unaffected by truncation.
// - One descriptor per held reservation, unit-wide or per element.
// - Descriptor is sixteen bytes: key, address, reserved, scope/type, legacy.
// - Descriptor gives the holding key and the scope and type as supplied.
// - Element scope pads element address with zeros; unit scope gives zero address.
// - Service action selects keys, reservations or capabilities; others are reserved. Capabilities flag a bad action here, with no reply.
// - Scope code zero is whole unit, two is element, one is obsolete.
`timescale 1ns/1ps
`include "rrf_regs.svh"
module rrf_formatter
  import rrf_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output rrf_byte_t        DATA_OUT,
  output logic             DATA_VALID,
  input  wire logic        DATA_READY,
  output logic             BUSY
);
  rrf_state_t st_reg;
  rrf_state_t st_next;
  rrf_entry_t rd_ent;
  rrf_entry_t wr_ent;
  logic       reply_busy;

  // Merge a written word into a register under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  // Byte i of a 128-bit field, most significant first
  function automatic logic [7:0] msb_byte(input logic [127:0] v, input logic [3:0] i);
    return v[8'd127 - {i, 3'b000} -: 8];
  endfunction : msb_byte

  // Number of set bits in an entry mask
  function automatic logic [3:0] popcnt(input logic [7:0] m);
    logic [3:0] c;
    c = 4'd0;
    for (int i = 0; i < 8; i++) c = c + {3'd0, m[i]};
    return c;
  endfunction : popcnt

  // First set bit at or above index from; RRF_NO_ENTRY when none
  function automatic logic [3:0] next_valid(input logic [7:0] m, input logic [3:0] from);
    logic [3:0] r;
    r = `RRF_NO_ENTRY;
    for (int i = 7; i >= 0; i--) begin
      if (m[i] && (4'(i) >= from)) r = 4'(i);
    end
    return r;
  endfunction : next_valid

  // True when a reserve-out outcome must advance the generation count
  function automatic logic gen_moves(input logic [31:0] w);
    logic [4:0] code;
    code = w[4:0];
    if (w[`RRF_EVT_REJ_BIT]) return 1'b0;
    return (code == `RRF_PO_REGISTER) || (code == `RRF_PO_CLEAR)
           || (code == `RRF_PO_PREEMPT) || (code == `RRF_PO_PREEMPT_AB);
  endfunction : gen_moves

  // True for the reserve-in actions that produce a reply
  function automatic logic is_read_sa(input logic [4:0] sa);
    return (sa == `RRF_SA_READ_KEYS) || (sa == `RRF_SA_READ_RES);
  endfunction : is_read_sa

  // True when the byte at pos is the final one under the limit
  function automatic logic is_last(input logic [15:0] pos, input logic [15:0] lim);
    return (pos + 16'd1 == lim);
  endfunction : is_last

  // Scope-specific address: element address widened, zero for the whole unit
  function automatic logic [31:0] scope_addr(input rrf_entry_t e);
    return (e.scope == `RRF_SCOPE_ELEM) ? {16'd0, e.elem_addr} : 32'd0;
  endfunction : scope_addr

  // Additional length: eight bytes per key or sixteen per descriptor
  function automatic logic [15:0] list_bytes(input logic keys, input logic [7:0] m);
    logic [15:0] n;
    n = {12'd0, popcnt(m)};
    return keys ? (n << `RRF_KEY_SHIFT) : (n << `RRF_DESC_SHIFT);
  endfunction : list_bytes

  // Offset of the final byte of a key or a descriptor record
  function automatic logic [3:0] rec_end(input logic keys);
    return keys ? (`RRF_KEY_LEN - 4'd1) : `RRF_DESC_LEN;
  endfunction : rec_end

  // Staged entry written to the table on an entry-control write
  assign wr_ent = '{key: {st_reg.key_hi, st_reg.key_lo}, elem_addr: st_reg.elem,
                    scope: st_reg.ent_ctrl[7:4], rtype: st_reg.ent_ctrl[3:0]};

  // Key and reservation table, one entry written per control write
  rrf_table_mem u_mem (
    .clk   (REF_CLK),
    .we    (st_reg.mem_we),
    .waddr (st_reg.tbl_idx),
    .wdata (wr_ent),
    .raddr (st_reg.rd_idx[2:0]),
    .rdata (rd_ent)
  );

  // Bus handshake and stream outputs
  assign S_AXI_AWREADY = !st_reg.aw_pend && !st_reg.bvalid;
  assign S_AXI_WREADY  = !st_reg.w_pend && !st_reg.bvalid;
  assign S_AXI_BVALID  = st_reg.bvalid;
  assign S_AXI_BRESP   = st_reg.bresp;
  assign S_AXI_ARREADY = !st_reg.rvalid;
  assign S_AXI_RVALID  = st_reg.rvalid;
  assign S_AXI_RDATA   = st_reg.rdata;
  assign S_AXI_RRESP   = st_reg.rresp;
  assign DATA_VALID    = st_reg.out_vld;
  assign DATA_OUT      = st_reg.out;
  assign BUSY          = reply_busy;

  // Busy until the final byte has left the output register
  assign reply_busy = (st_reg.fsm != S_IDLE) || st_reg.out_vld;

  // Next-state logic of bus slave, table, counter and stream
  always_comb begin
    logic [127:0] rec;
    logic [15:0]  total;
    logic [15:0]  alen;
    logic [7:0]   mask;
    logic [3:0]   nxt;
    logic         emit;
    logic         take;
    logic         busy;
    logic [7:0]   wa;
    logic [31:0]  wd;
    // Defaults: hold every register, no table write
    st_next = st_reg;
    st_next.mem_we = 1'b0;
    busy  = reply_busy;
    take  = 1'b0;
    mask  = st_reg.keys ? st_reg.reg_vld : st_reg.res_vld;
    emit  = 1'b0;
    alen  = 16'd0;
    total = 16'd0;
    nxt   = 4'd0;
    wa    = st_reg.aw_addr;
    wd    = st_reg.w_data;
    rec   = 128'd0;
    // Write address and data are taken in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      st_next.aw_pend = 1'b1;
      st_next.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      st_next.w_pend = 1'b1;
      st_next.w_data = S_AXI_WDATA;
      st_next.w_strb = S_AXI_WSTRB;
    end
    // Response taken by the master
    if (st_reg.bvalid && S_AXI_BREADY) st_next.bvalid = 1'b0;
    // Both halves of the write are held
    take = st_reg.aw_pend && st_reg.w_pend;
    // Register writes, answered one cycle after both halves are held
    if (take) begin
      st_next.aw_pend = 1'b0;
      st_next.w_pend  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = `RRF_BRESP_OK;
      unique case (wa)
        `RRF_A_OUT_EVT: begin
          if (gen_moves(wd)) begin
            st_next.gen = st_reg.gen + 32'd1;
          end
        end
        `RRF_A_ALLOC:   st_next.alloc   = 16'(merge({16'd0, st_reg.alloc}, wd, st_reg.w_strb));
        `RRF_A_TBL_IDX: st_next.tbl_idx = 3'(merge({29'd0, st_reg.tbl_idx}, wd, st_reg.w_strb));
        `RRF_A_KEY_HI:  st_next.key_hi  = merge(st_reg.key_hi, wd, st_reg.w_strb);
        `RRF_A_KEY_LO:  st_next.key_lo  = merge(st_reg.key_lo, wd, st_reg.w_strb);
        `RRF_A_ELEM:    st_next.elem    = 16'(merge({16'd0, st_reg.elem}, wd, st_reg.w_strb));
        `RRF_A_ENT_CTRL: begin
          // Table is frozen while a reply is being built
          if (!busy) begin
            st_next.ent_ctrl = wd[9:0];
            st_next.mem_we   = 1'b1;
            st_next.reg_vld[st_reg.tbl_idx] = wd[`RRF_ENT_REG_BIT];
            st_next.res_vld[st_reg.tbl_idx] = wd[`RRF_ENT_RES_BIT];
          end
        end
        `RRF_A_START: begin
          if (!busy) begin
            st_next.sa = wd[4:0];
            unique case (wd[4:0])
              `RRF_SA_READ_KEYS: begin
                alen = list_bytes(1'b1, st_reg.reg_vld);
                st_next.keys = 1'b1;
              end
              `RRF_SA_READ_RES: begin
                alen = list_bytes(1'b0, st_reg.res_vld);
                st_next.keys = 1'b0;
              end
              default: alen = 16'd0;
            endcase
            if (is_read_sa(wd[4:0])) begin
              total = `RRF_HDR_LEN + alen;
              st_next.err      = 1'b0;
              st_next.addlen   = alen;
              st_next.limit    = (st_reg.alloc < total) ? st_reg.alloc : total;
              st_next.snap_gen = st_reg.gen;
              st_next.pos      = 16'd0;
              st_next.rd_idx   = 4'd0;
              st_next.fsm      = (st_next.limit == 16'd0) ? S_IDLE : S_HDR;
            end else begin
              st_next.err = 1'b1;
            end
          end
        end
        `RRF_A_GEN, `RRF_A_STATUS, `RRF_A_VALID: ;
        default: st_next.bresp = `RRF_BRESP_ERR;
      endcase
    end
    // Register reads, answered the cycle after the address is taken
    if (st_reg.rvalid && S_AXI_RREADY) st_next.rvalid = 1'b0;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = `RRF_BRESP_OK;
      unique case (S_AXI_ARADDR)
        `RRF_A_GEN:      st_next.rdata = st_reg.gen;
        `RRF_A_OUT_EVT:  st_next.rdata = 32'd0;
        `RRF_A_ALLOC:    st_next.rdata = {16'd0, st_reg.alloc};
        `RRF_A_START:    st_next.rdata = {27'd0, st_reg.sa};
        `RRF_A_STATUS:   st_next.rdata = {st_reg.pos, 14'd0, st_reg.err, busy};
        `RRF_A_TBL_IDX:  st_next.rdata = {29'd0, st_reg.tbl_idx};
        `RRF_A_KEY_HI:   st_next.rdata = st_reg.key_hi;
        `RRF_A_KEY_LO:   st_next.rdata = st_reg.key_lo;
        `RRF_A_ELEM:     st_next.rdata = {16'd0, st_reg.elem};
        `RRF_A_ENT_CTRL: st_next.rdata = {22'd0, st_reg.ent_ctrl};
        `RRF_A_VALID:    st_next.rdata = {16'd0, st_reg.res_vld, st_reg.reg_vld};
        default: begin
          st_next.rdata = 32'd0;
          st_next.rresp = `RRF_BRESP_ERR;
        end
      endcase
    end
    // Output byte register drains on ready
    if (st_reg.out_vld && DATA_READY) st_next.out_vld = 1'b0;
    emit = !st_reg.out_vld || DATA_READY;
    // Record image of the fetched entry
    rec[127:64] = rd_ent.key;
    rec[63:32]  = scope_addr(rd_ent);
    rec[23:16]  = {rd_ent.scope, rd_ent.rtype};
    // Reply sequencer
    unique case (st_reg.fsm)
      S_IDLE: ;
      S_HDR: begin
        if (emit) begin
          st_next.out_vld   = 1'b1;
          st_next.out.data  = msb_byte({st_reg.snap_gen, 16'd0, st_reg.addlen, 64'd0},
                                       st_reg.pos[3:0]);
          st_next.out.last  = is_last(st_reg.pos, st_reg.limit);
          st_next.pos       = st_reg.pos + 16'd1;
          if (st_next.out.last) st_next.fsm = S_IDLE;
          else if (st_reg.pos == `RRF_HDR_LEN - 16'd1) st_next.fsm = S_FETCH;
        end
      end
      S_FETCH: begin
        // Next flagged entry; its table read lands two cycles later
        nxt = next_valid(mask, st_reg.rd_idx);
        st_next.rd_idx  = nxt;
        st_next.rec_off = 4'd0;
        st_next.fsm     = (nxt == `RRF_NO_ENTRY) ? S_IDLE : S_WAIT;
      end
      S_WAIT: st_next.fsm = S_BODY;
      S_BODY: begin
        if (emit) begin
          st_next.out_vld  = 1'b1;
          st_next.out.data = msb_byte(rec, st_reg.rec_off);
          st_next.out.last = is_last(st_reg.pos, st_reg.limit);
          st_next.pos      = st_reg.pos + 16'd1;
          st_next.rec_off  = st_reg.rec_off + 4'd1;
          if (st_next.out.last) begin
            st_next.fsm = S_IDLE;
          end else if (st_reg.rec_off == rec_end(st_reg.keys)) begin
            st_next.rd_idx = st_reg.rd_idx + 4'd1;
            st_next.fsm    = S_FETCH;
          end
        end
      end
    endcase
  end

  // State register; counter starts at zero on every reset
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg     <= '0;
      st_reg.fsm <= S_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : rrf_formatter

/* testbench/rrf_chk.sv */
/*
  Checker of the formatter's bus and byte-stream handshakes.
  Assumes it is bound to rrf_formatter and sees only its ports.
*/
`timescale 1ns/1ps
module rrf_chk
  import rrf_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input rrf_byte_t        DATA_OUT,
  input wire logic        DATA_VALID,
  input wire logic        DATA_READY,
  input wire logic        BUSY
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  // Stream bytes stand until taken and only while a reply is built
  chk_byte_hold: assert property (DATA_VALID && !DATA_READY |=>
    DATA_VALID && $stable(DATA_OUT)) else $error("byte changed while stalled");
  chk_byte_busy: assert property (DATA_VALID |-> BUSY)
    else $error("byte offered while idle");
  chk_last_ends: assert property (DATA_VALID && DATA_READY && DATA_OUT.last |=>
    !DATA_VALID ##[0:3] !BUSY) else $error("reply continues after last byte");
  // Register bus answers
  chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
  chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
  chk_ar_gate: assert property (S_AXI_ARREADY == !S_AXI_RVALID)
    else $error("read address ready wrong");
  chk_r_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered next cycle");
  chk_w_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while response pending");
endmodule : rrf_chk

bind rrf_formatter rrf_chk chk_u (.REF_CLK, .RST_N, .S_AXI_AWREADY, .S_AXI_WREADY,
  .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .DATA_OUT, .DATA_VALID,
  .DATA_READY, .BUSY);

/* testbench/rrf_sink.sv */
/*
  Initiator-side byte sink: records every byte taken.
  Assumes a valid/ready stream; stall makes ready toggle.
*/
`timescale 1ns/1ps
module rrf_sink
  import rrf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input rrf_byte_t data,
  input wire logic valid,
  input wire logic stall,
  output logic     ready
);
  rrf_byte_t got [$];

  // Take whatever length is offered; stall slows acceptance
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready <= 1'b0;
    end else begin
      if (valid && ready) got.push_back(data);
      ready <= stall ? ~ready : 1'b1;
    end
  end
endmodule : rrf_sink

/* testbench/reservation_report_formatter_test.sv */
/*
  Self-checking bench of the reservation report formatter.
  Assumes rrf_formatter, the rrf_sink partner and the bound checker.
*/
`timescale 1ns/1ps
`include "rrf_regs.svh"
module reservation_report_formatter_test
  import rrf_pkg::*;
;
  logic        clk = 0, rst_n = 0;
  logic [7:0]  aw = 0, ar = 0;
  logic [31:0] wd = 0, gen = 0, v;
  logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, stall = 0;
  logic [1:0]  r;
  wire         awr, wr_r, bv, arr, rv, dv, ready, busy;
  wire [1:0]   br, rr;
  wire [31:0]  rd_d;
  rrf_byte_t   dout;
  logic [63:0] ek [8];
  logic [15:0] ee [8];
  logic [3:0]  es [8], et [8];
  bit          er [8], ev [8];
  logic [7:0]  exq [$];
  int          miscompares = 0, n_tests = 0;

  rrf_formatter dut_u (.REF_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(aw),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bry), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd_d), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
    .DATA_OUT(dout), .DATA_VALID(dv), .DATA_READY(ready), .BUSY(busy));
  rrf_sink sink_u (.clk(clk), .rst_n(rst_n), .data(dout), .valid(dv),
    .stall(stall), .ready(ready));

  // Clock and watchdog
  initial forever #5 clk = ~clk;
  initial begin
    #300us;
    miscompares++;
    end_of_test();
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    aw <= a; wd <= d; awv <= 1; wv <= 1; bry <= !stall;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wr_r) wv <= 0;
      if (bv && !bry) bry <= 1;
    end while (!(bv && bry));
    rs = br;
    bry <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    ar <= a; arv <= 1; rry <= !stall;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rv && !rry) rry <= 1;
    end while (!(rv && rry));
    d = rd_d; rs = rr;
    rry <= 0;
  endtask : rd

  task automatic put(input int i, input logic [63:0] k, input logic [15:0] e,
                     input logic [3:0] s, input logic [3:0] t, input bit g, input bit h);
    ek[i] = k; ee[i] = e; es[i] = s; et[i] = t; er[i] = g; ev[i] = h;
    wr(`RRF_A_TBL_IDX, i, r);
    wr(`RRF_A_KEY_HI, k[63:32], r);
    wr(`RRF_A_KEY_LO, k[31:0], r);
    wr(`RRF_A_ELEM, {16'h0, e}, r);
    wr(`RRF_A_ENT_CTRL, {22'h0, h, g, s, t}, r);
  endtask : put

  // Expected reply: header, keys or descriptors, cut to allocation
  function automatic void build(input bit k, input int al);
    logic [7:0]  b [$];
    logic [31:0] a;
    for (int i = 0; i < 8; i++) begin
      if (k && er[i]) for (int j = 7; j >= 0; j--) b.push_back(ek[i][j*8+:8]);
      if (!k && ev[i]) begin
        a = (es[i] == `RRF_SCOPE_ELEM) ? {16'h0, ee[i]} : 32'h0;
        for (int j = 7; j >= 0; j--) b.push_back(ek[i][j*8+:8]);
        for (int j = 3; j >= 0; j--) b.push_back(a[j*8+:8]);
        b.push_back(8'h00); b.push_back({es[i], et[i]}); b.push_back(8'h00);
        b.push_back(8'h00);
      end
    end
    a = b.size();
    exq = {gen[31:24], gen[23:16], gen[15:8], gen[7:0], a[31:24], a[23:16], a[15:8], a[7:0]};
    exq = {exq, b};
    while (exq.size() > al) void'(exq.pop_back());
  endfunction : build

  task automatic run(input logic [4:0] sa, input int al);
    int n;
    sink_u.got.delete();
    if (sa > 1) exq = {};
    else build(sa == 0, al);
    wr(`RRF_A_ALLOC, al, r);
    wr(`RRF_A_START, {27'h0, sa}, r);
    n = 0;
    repeat (3) @(posedge clk);
    while (busy && n < 3000) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
    chk("reply finished", 0, busy);
    chk("byte count", exq.size(), sink_u.got.size());
    foreach (exq[i]) if (i < sink_u.got.size()) begin
      chk("reply byte", exq[i], sink_u.got[i].data);
      chk("last flag", i == exq.size() - 1, sink_u.got[i].last);
    end
  endtask : run

  task automatic t_reset;
    rd(`RRF_A_GEN, v, r);
    chk("count after reset", 0, v);
    rd(8'h3c, v, r);
    chk("unmapped response", `RRF_BRESP_ERR, r);
    wr(8'h3c, 32'h0, r);
    chk("unmapped write response", `RRF_BRESP_ERR, r);
  endtask : t_reset

  task automatic t_gen;
    for (int c = 0; c < 8; c++) for (int j = 0; j < 2; j++) begin
      wr(`RRF_A_OUT_EVT, {23'h0, j[0], 3'h0, c[4:0]}, r);
      if (j == 0 && (c == 0 || c == 3 || c == 4 || c == 5)) gen++;
      rd(`RRF_A_GEN, v, r);
      chk("generation count", gen, v);
    end
  endtask : t_gen

  task automatic t_lists;
    put(0, 64'h0123_4567_89ab_cdef, 16'h5555, `RRF_SCOPE_UNIT, 4'h1, 1, 1);
    put(2, 64'hfedc_ba98_7654_3210, 16'h1234, `RRF_SCOPE_ELEM, 4'h3, 1, 1);
    put(5, 64'h8000_0000_0000_0001, 16'h0, `RRF_SCOPE_UNIT, 4'h0, 1, 0);
    put(7, 64'h0f0f_0f0f_0f0f_0f0f, 16'hffff, `RRF_SCOPE_ELEM, 4'h5, 0, 1);
    run(`RRF_SA_READ_KEYS, 16'hffff);
    run(`RRF_SA_READ_RES, 16'hffff);
    rd(`RRF_A_GEN, v, r);
    chk("count after reads", gen, v);
  endtask : t_lists

  task automatic t_trunc;
    stall <= 1;
    run(`RRF_SA_READ_KEYS, 13);
    run(`RRF_SA_READ_RES, 5);
    run(`RRF_SA_READ_RES, 0);
    rd(`RRF_A_GEN, v, r);
    chk("count under stall", gen, v);
    stall <= 0;
  endtask : t_trunc

  task automatic t_bad;
    for (int c = 2; c < 4; c++) begin
      run(c[4:0], 64);
      rd(`RRF_A_STATUS, v, r);
      chk("error flag", 1, v[1]);
    end
  endtask : t_bad

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_gen();
    t_lists();
    t_trunc();
    t_bad();
    end_of_test();
  end
endmodule : reservation_report_formatter_test
